// file: hdl/hbd_defs.vh
// Shared constants for the host bus decode and lane steering block.
`ifndef HBD_DEFS_VH
`define HBD_DEFS_VH

`define HBD_ADDR_MSB 15
`define HBD_ADDR_LSB 1
`define HBD_DEC_LSB 4
`define HBD_ADDR_W 15
`define HBD_BASE_W 12

`define HBD_SYNC_W 22
`define HBD_SYNC_RST 22'h3F8000
`define HBD_SY_ADDR_LO 0
`define HBD_SY_ADDR_HI 14
`define HBD_SY_QUAL 15
`define HBD_SY_BE_LO 16
`define HBD_SY_BE_HI 19
`define HBD_SY_STROBE 20
`define HBD_SY_DCS 21

`define HBD_BE_WORD 4'h0
`define HBD_BE_LOWER 4'hC
`define HBD_BE_UPPER 4'h3
`define HBD_BE_BYTE0 4'hE
`define HBD_BE_BYTE1 4'hD
`define HBD_BE_BYTE2 4'hB
`define HBD_BE_BYTE3 4'h7
`define HBD_BE_IDLE 4'hF

`define HBD_EN_NONE 4'h0
`define HBD_EN_WORD 4'hF
`define HBD_EN_LOWER 4'h3
`define HBD_EN_UPPER 4'hC
`define HBD_EN_BYTE0 4'h1
`define HBD_EN_BYTE1 4'h2
`define HBD_EN_BYTE2 4'h4
`define HBD_EN_BYTE3 4'h8
`define HBD_LOW_PAIR 4'h3

`define HBD_ADDR_RST 15'h0000
`define HBD_QUAL_IDLE 1'h1
`define HBD_BASE_RST 12'h000

`endif

// file: hdl/hbd_pin_sync.v
// Three-stage pin synchroniser with an agreement filter on the last two stages.
`timescale 1ns/1ns
`default_nettype none
module hbd_pin_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'h0}}
) (
	input wire core_clk,
	input wire rst,
	input wire [W-1:0] pin_in,
	output reg [W-1:0] level_out
);
	reg [W-1:0] stage1_reg;
	reg [W-1:0] stage2_reg;
	reg [W-1:0] stage3_reg;
	integer i;

	// Stage one feeds stage two only, so a metastable value never reaches logic.
	always @(posedge core_clk) begin
		if (rst) begin
			stage1_reg <= RST_VAL;
			stage2_reg <= RST_VAL;
			stage3_reg <= RST_VAL;
			level_out <= RST_VAL;
		end else begin
			stage1_reg <= pin_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			for (i = 0; i < W; i = i + 1) begin
				if (stage2_reg[i] == stage3_reg[i]) begin
					level_out[i] <= stage3_reg[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/hbd_top.v
// Host bus address latch, local decode and byte lane steering.
`timescale 1ns/1ns
`default_nettype none
`include "hbd_defs.vh"

// Notes on behaviour
// R1: Lanes 0,1 low select the lower half-word; lanes 2,3 low the upper.
// R2: One enable low selects one byte: lane 0 bits 7:0, lane 1 bits 15:8.
// R3: Full word and single upper-byte patterns are valid only on the wide bus.
// R4: Address, qualify and all four lane selects are caught on strobe rising edge.
// R5: Local hit output is combinational from qualify and address bits 15:4.
// R6: Local decode compares address bits 15:4 against the base address.
// R7: With data port select asserted the local decode result is ignored; the code does this on the wide bus only.
// R8: With data port select asserted the access is a full word, lanes ignored; the code does this on the wide bus only.
// R9: Decoding is enabled only while qualify is low; host raises it for DMA.
// R10: Through data port select only the data register may be reached.
// R11: A host with stable addresses ties the strobe low; the latch stays open.
// R12: Undefined lane patterns enable no lane and block register writes.
// R13: On the narrow bus the upper lane selects and data lanes are ignored.
module hbd_top (
	input wire core_clk,
	input wire rst,
	input wire bus_width_32,
	input wire [`HBD_BASE_W-1:0] base_address,
	input wire [`HBD_ADDR_MSB:`HBD_ADDR_LSB] addr_in,
	input wire address_qualify,
	input wire lane0_select_n,
	input wire lane1_select_n,
	input wire lane2_select_n,
	input wire lane3_select_n,
	input wire address_strobe_n,
	input wire data_port_select_n,
	output wire local_hit_n,
	output reg [`HBD_ADDR_MSB:`HBD_ADDR_LSB] latched_addr_reg,
	output reg [3:0] lane_enable_reg,
	output reg target_hit_reg,
	output reg data_reg_select_reg,
	output reg other_reg_allow_reg,
	output reg write_allow_reg,
	output reg full_word_reg,
	output reg wide_bus_reg
);
	wire [`HBD_SYNC_W-1:0] pins_raw;
	wire [`HBD_SYNC_W-1:0] pins_sync;
	wire [`HBD_ADDR_MSB:`HBD_ADDR_LSB] sync_addr;
	wire sync_qualify;
	wire [3:0] sync_lanes_n;
	wire sync_strobe_n;
	wire sync_dcs_n;
	reg latched_qualify_reg;
	reg [3:0] latched_lanes_n_reg;
	reg [`HBD_ADDR_MSB:`HBD_ADDR_LSB] latched_addr_next;
	reg latched_qualify_next;
	reg [3:0] latched_lanes_n_next;
	reg [`HBD_BASE_W-1:0] base_reg;
	reg [3:0] lane_enable_next;
	reg target_hit_next;
	reg data_reg_select_next;
	reg other_reg_allow_next;
	reg write_allow_next;
	reg full_word_next;
	wire local_match;
	wire central_select;

	// Lane enables for one active-low pattern; anything undefined reaches no lane.
	function [3:0] hbd_lane_decode;
		input [3:0] lanes_n;
		input wide;
		begin
			hbd_lane_decode = `HBD_EN_NONE; // see R12
			if (wide) begin
				case (lanes_n)
					`HBD_BE_WORD: hbd_lane_decode = `HBD_EN_WORD; // see R3
					`HBD_BE_LOWER: hbd_lane_decode = `HBD_EN_LOWER; // see R1
					`HBD_BE_UPPER: hbd_lane_decode = `HBD_EN_UPPER; // see R1
					`HBD_BE_BYTE0: hbd_lane_decode = `HBD_EN_BYTE0; // see R2
					`HBD_BE_BYTE1: hbd_lane_decode = `HBD_EN_BYTE1; // see R2
					`HBD_BE_BYTE2: hbd_lane_decode = `HBD_EN_BYTE2; // see R3
					`HBD_BE_BYTE3: hbd_lane_decode = `HBD_EN_BYTE3; // see R3
					default: hbd_lane_decode = `HBD_EN_NONE; // see R12
				endcase
			end else begin
				// The narrow variant looks at the lower pair only.
				case (lanes_n & `HBD_LOW_PAIR)
					(`HBD_BE_LOWER & `HBD_LOW_PAIR): begin
						hbd_lane_decode = `HBD_EN_LOWER; // see R1, see R13
					end
					(`HBD_BE_BYTE0 & `HBD_LOW_PAIR): begin
						hbd_lane_decode = `HBD_EN_BYTE0; // see R2, see R13
					end
					(`HBD_BE_BYTE1 & `HBD_LOW_PAIR): begin
						hbd_lane_decode = `HBD_EN_BYTE1; // see R2, see R13
					end
					default: hbd_lane_decode = `HBD_EN_NONE; // see R12
				endcase
			end
		end
	endfunction

	assign pins_raw = {data_port_select_n, address_strobe_n, lane3_select_n, lane2_select_n,
		lane1_select_n, lane0_select_n, address_qualify, addr_in};

	hbd_pin_sync #(
		.W(`HBD_SYNC_W),
		.RST_VAL(`HBD_SYNC_RST)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(pins_raw),
		.level_out(pins_sync)
	);

	assign sync_addr = pins_sync[`HBD_SY_ADDR_HI:`HBD_SY_ADDR_LO];
	assign sync_qualify = pins_sync[`HBD_SY_QUAL];
	assign sync_lanes_n = pins_sync[`HBD_SY_BE_HI:`HBD_SY_BE_LO];
	assign sync_strobe_n = pins_sync[`HBD_SY_STROBE];
	assign sync_dcs_n = pins_sync[`HBD_SY_DCS];

	// The latch is open while the strobe is low and closes on its rising edge,
	// so a strobe tied low simply lets stable addresses flow through.
	always @* begin
		latched_addr_next = latched_addr_reg;
		latched_qualify_next = latched_qualify_reg;
		latched_lanes_n_next = latched_lanes_n_reg;
		if (!sync_strobe_n) begin
			latched_addr_next = sync_addr; // see R4, see R11
			latched_qualify_next = sync_qualify; // see R4, see R11
			latched_lanes_n_next = sync_lanes_n; // see R4, see R11
		end
	end

	// Hit is pure gating on the latched values; there is no flop in this path.
	assign local_match = (latched_addr_reg[`HBD_ADDR_MSB:`HBD_DEC_LSB] == base_reg); // see R6
	assign local_hit_n = ~(~latched_qualify_reg & local_match); // see R5, see R9

	// Central select exists only on the wide variant; the narrow one ignores it.
	assign central_select = wide_bus_reg & ~sync_dcs_n;

	always @* begin
		lane_enable_next = hbd_lane_decode(latched_lanes_n_reg, wide_bus_reg);
		target_hit_next = ~local_hit_n;
		data_reg_select_next = 1'h0;
		other_reg_allow_next = ~local_hit_n;
		full_word_next = (lane_enable_next == `HBD_EN_WORD);
		if (central_select) begin
			target_hit_next = 1'h1; // see R7
			lane_enable_next = `HBD_EN_WORD; // see R8
			full_word_next = 1'h1; // see R8
			data_reg_select_next = 1'h1; // see R8
			other_reg_allow_next = 1'h0; // see R10
		end
		write_allow_next = target_hit_next & (lane_enable_next != `HBD_EN_NONE); // see R12
	end

	// The width strap is caught only during reset so it cannot shift mid-access.
	// The base follows its port one cycle late, so change it only while the bus is idle.
	always @(posedge core_clk) begin
		if (rst) begin
			wide_bus_reg <= bus_width_32;
			base_reg <= base_address;
			latched_addr_reg <= `HBD_ADDR_RST;
			latched_qualify_reg <= `HBD_QUAL_IDLE;
			latched_lanes_n_reg <= `HBD_BE_IDLE;
			lane_enable_reg <= `HBD_EN_NONE;
			target_hit_reg <= 1'h0;
			data_reg_select_reg <= 1'h0;
			other_reg_allow_reg <= 1'h0;
			write_allow_reg <= 1'h0;
			full_word_reg <= 1'h0;
		end else begin
			base_reg <= base_address;
			latched_addr_reg <= latched_addr_next;
			latched_qualify_reg <= latched_qualify_next;
			latched_lanes_n_reg <= latched_lanes_n_next;
			lane_enable_reg <= lane_enable_next;
			target_hit_reg <= target_hit_next;
			data_reg_select_reg <= data_reg_select_next;
			other_reg_allow_reg <= other_reg_allow_next;
			write_allow_reg <= write_allow_next;
			full_word_reg <= full_word_next;
		end
	end
endmodule
`default_nettype wire

// file: tb/hbd_checker.sv
// Concurrent checks on the decode and lane steering outputs.
`timescale 1ns/1ns
`default_nettype none
module hbd_checker (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] base_address,
	input wire logic address_qualify,
	input wire logic address_strobe_n,
	input wire logic data_port_select_n,
	input wire logic local_hit_n,
	input wire logic [15:1] latched_addr_reg,
	input wire logic [3:0] lane_enable_reg,
	input wire logic target_hit_reg,
	input wire logic data_reg_select_reg,
	input wire logic other_reg_allow_reg,
	input wire logic write_allow_reg,
	input wire logic full_word_reg,
	input wire logic wide_bus_reg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_idle; address_strobe_n [*8]; endsequence
	sequence s_cs; (wide_bus_reg && !data_port_select_n) [*7]; endsequence
	sequence s_dma; (address_qualify && !address_strobe_n) [*8]; endsequence
	property p_hold; s_idle |-> $stable(latched_addr_reg); endproperty
	property p_base; !local_hit_n |-> latched_addr_reg[15:4] == $past(base_address); endproperty
	property p_dma; s_dma |-> local_hit_n; endproperty
	property p_cs; s_cs |-> data_reg_select_reg && lane_enable_reg == 4'hF; endproperty
	property p_only; data_reg_select_reg |-> target_hit_reg && !other_reg_allow_reg; endproperty
	property p_other; other_reg_allow_reg |-> !$past(local_hit_n); endproperty
	property p_write; write_allow_reg == (target_hit_reg && lane_enable_reg != 4'h0); endproperty
	property p_word; full_word_reg == (lane_enable_reg == 4'hF); endproperty
	property p_narrow; !wide_bus_reg |-> lane_enable_reg[3:2] == 2'h0; endproperty
	a_hold: assert property (p_hold) else $error("latch moved");
	a_base: assert property (p_base) else $error("hit off base");
	a_dma: assert property (p_dma) else $error("hit on dma");
	a_cs: assert property (p_cs) else $error("select lost");
	a_only: assert property (p_only) else $error("other reach");
	a_other: assert property (p_other) else $error("other no hit");
	a_write: assert property (p_write) else $error("write flag");
	a_word: assert property (p_word) else $error("word flag");
	a_narrow: assert property (p_narrow) else $error("upper lanes");
endmodule
bind hbd_top hbd_checker i_hbd_checker (.core_clk, .rst, .base_address, .address_qualify,
	.address_strobe_n, .data_port_select_n, .local_hit_n, .latched_addr_reg, .lane_enable_reg,
	.target_hit_reg, .data_reg_select_reg, .other_reg_allow_reg, .write_allow_reg,
	.full_word_reg, .wide_bus_reg);
`default_nettype wire

// file: tb/hbd_host_model.sv
// Host side pin driver standing in for the processor and its glue logic.
`timescale 1ns/1ns
`default_nettype none
module hbd_host_model (
	input wire logic core_clk,
	output logic [15:1] addr_in,
	output logic address_qualify,
	output logic [3:0] lanes_n,
	output logic address_strobe_n,
	output logic data_port_select_n
);
	initial begin
		{addr_in, address_qualify, lanes_n, address_strobe_n, data_port_select_n} = 22'h3FFFFF;
	end
	task automatic start(input logic [15:1] a, input logic q, input logic [3:0] l, input logic cs);
		@(posedge core_clk);
		#1;
		{addr_in, address_qualify, lanes_n, address_strobe_n, data_port_select_n} = {a, q, l, 1'h0, cs};
		repeat (7) @(posedge core_clk);
	endtask
	// Released lines flip so that a latch that kept following them would show it.
	task automatic finish();
		@(posedge core_clk);
		#1;
		{addr_in, address_qualify, lanes_n} = ~{addr_in, address_qualify, lanes_n};
		{address_strobe_n, data_port_select_n} = 2'h3;
		repeat (7) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// file: tb/hbd_top_tb.sv
// Self-checking bench for the host bus decode and lane steering block.
`timescale 1ns/1ns
`default_nettype none
module hbd_top_tb;
	localparam logic [11:0] BASE = 12'hA5C;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic bus_width_32 = 1'h1;
	logic [15:1] addr_in;
	logic [3:0] lanes_n;
	logic address_qualify, address_strobe_n, data_port_select_n;
	wire [25:0] outs;
	int err_count = 0;
	int comparisons = 0;
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	hbd_host_model i_hbd_host_model (.core_clk, .addr_in, .address_qualify, .lanes_n,
		.address_strobe_n, .data_port_select_n);
	hbd_top i_hbd_top (.core_clk, .rst, .bus_width_32, .base_address(BASE), .addr_in,
		.address_qualify, .lane0_select_n(lanes_n[0]), .lane1_select_n(lanes_n[1]),
		.lane2_select_n(lanes_n[2]), .lane3_select_n(lanes_n[3]), .address_strobe_n,
		.data_port_select_n, .local_hit_n(outs[25]), .latched_addr_reg(outs[24:10]),
		.lane_enable_reg(outs[9:6]), .target_hit_reg(outs[5]), .data_reg_select_reg(outs[4]),
		.other_reg_allow_reg(outs[3]), .write_allow_reg(outs[2]), .full_word_reg(outs[1]),
		.wide_bus_reg(outs[0]));
	task automatic close_out();
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [25:0] seen, input logic [25:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: outputs %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [3:0] exp_en(input logic [3:0] l, input logic w);
		if (!w)
			return l[1:0] == 2'h0 ? 4'h3 : l[1:0] == 2'h2 ? 4'h1 : l[1:0] == 2'h1 ? 4'h2 : 4'h0;
		case (l)
			4'h0: return 4'hF;
			4'hC: return 4'h3;
			4'h3: return 4'hC;
			4'hE: return 4'h1;
			4'hD: return 4'h2;
			4'hB: return 4'h4;
			4'h7: return 4'h8;
			default: return 4'h0;
		endcase
	endfunction
	function automatic logic [25:0] exp_out(input logic [15:1] a, input logic q,
		input logic [3:0] l, input logic cs);
		logic hit;
		logic sel;
		logic [3:0] en;
		hit = !q && a[15:4] == BASE;
		sel = !cs && bus_width_32;
		en = sel ? 4'hF : exp_en(l, bus_width_32);
		return {!hit, a, en, hit || sel, sel, hit && !sel, (hit || sel) && en != 4'h0, en == 4'hF,
			bus_width_32};
	endfunction
	task automatic access(input logic [15:1] a, input logic q, input logic [3:0] l, input logic cs);
		logic [25:0] e;
		e = exp_out(a, q, l, cs);
		i_hbd_host_model.start(a, q, l, cs);
		// Look a moment after the edge so the outputs are settled, not racing their update.
		#1;
		check(outs, e);
		i_hbd_host_model.finish();
		#1;
		// Central select is not latched, so only accesses without central select must survive the release.
		if (cs)
			check(outs, e);
	endtask
	task automatic do_reset(input logic w);
		@(posedge core_clk);
		#1;
		rst = 1'h1;
		bus_width_32 = w;
		repeat (8) @(posedge core_clk);
		#1;
		rst = 1'h0;
	endtask
	logic [3:0] pats [8] = '{4'h0, 4'hC, 4'h3, 4'hE, 4'hD, 4'hB, 4'h7, 4'h5};
	task automatic t_lanes_wide();
		for (int i = 0; i < 8; i++)
			access({BASE, 3'h5}, 1'h0, pats[i], 1'h1);
	endtask
	task automatic t_miss();
		access({BASE ^ 12'h010, 3'h1}, 1'h0, 4'hC, 1'h1);
		access({BASE, 3'h2}, 1'h1, 4'hC, 1'h1);
	endtask
	task automatic t_central();
		access({~BASE, 3'h0}, 1'h0, 4'hE, 1'h0);
		access({BASE, 3'h4}, 1'h1, 4'h5, 1'h0);
	endtask
	// A host with stable addresses keeps the strobe low, so each new address flows through.
	task automatic t_flow();
		i_hbd_host_model.start({BASE, 3'h1}, 1'h0, 4'hE, 1'h1);
		#1;
		check(outs, exp_out({BASE, 3'h1}, 1'h0, 4'hE, 1'h1));
		i_hbd_host_model.start({BASE ^ 12'h001, 3'h7}, 1'h0, 4'hD, 1'h1);
		#1;
		check(outs, exp_out({BASE ^ 12'h001, 3'h7}, 1'h0, 4'hD, 1'h1));
		i_hbd_host_model.finish();
	endtask
	task automatic t_lanes_narrow();
		do_reset(1'h0);
		for (int i = 0; i < 8; i++)
			access({BASE, 3'h6}, 1'h0, pats[i], 1'h1);
		access({BASE, 3'h3}, 1'h0, 4'hC, 1'h0);
	endtask
	initial begin
		do_reset(1'h1);
		t_lanes_wide();
		t_miss();
		t_central();
		t_flow();
		t_lanes_narrow();
		close_out();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		close_out();
	end
endmodule
`default_nettype wire
